/* File: inc/rxd_consts.vh */
// Constants for the receive descriptor list DMA channel
`ifndef RXD_CONSTS_VH
`define RXD_CONSTS_VH

// ----------------------------------------
// APB register byte offsets
// ----------------------------------------
`define RXD_REG_CTRL 8'h00
`define RXD_REG_BASE 8'h04
`define RXD_REG_LAST 8'h08
`define RXD_REG_STAT 8'h0c
`define RXD_REG_CUR 8'h10

// ----------------------------------------
// Control register bits
// ----------------------------------------
`define RXD_CTRL_START 0
`define RXD_CTRL_LSEL 1
`define RXD_CTRL_CSSE 2
`define RXD_CTRL_CHAR 3
`define RXD_CTRL_RRST 4
`define RXD_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// Descriptor layout
// ----------------------------------------
`define RXD_DESC_WORDS 3'h5
`define RXD_FETCH_LEN 4'h3
`define RXD_W0_HOLD 31
`define RXD_W0_HI 30
`define RXD_SIZE_MSB 12
`define RXD_W3_DONE 31
`define RXD_W3_FE 30
`define RXD_W3_STAT_LSB 16
`define RXD_OFF_W3 32'h0000_000c
`define RXD_OFF_W4 32'h0000_0010
`define RXD_MAX_BURST 4'hf

// ----------------------------------------
// Write-back status codes
// ----------------------------------------
`define RXD_END_NORMAL 8'h00
`define RXD_END_RESET 8'h01
`define RXD_END_HOLD 8'h02

`endif

/* File: rtl/rxd_dma.v */
// Receive descriptor list DMA channel with APB control registers
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rxd_consts.vh"
// Notes on behaviour
// - Descriptors are five aligned words; word offsets three and four are written.
// - The first three descriptor words are fetched as one three-word burst.
// - Word four is written when the channel finishes a descriptor.
// - Word five goes only into a frame's first descriptor, after the frame.
// - Software loads the base address; start begins the list there.
// - Hold bit stops branching until restarted; ignored in last-address mode.
// - Host-requested bit pulses an interrupt after the descriptor completes.
// - Status bytes count as stored data and consume buffer space.
// - Buffer data is written as single-word writes from the start address.
// - Frame-end flag set on frame's last descriptor; frame-end interrupt follows.
// - Complete flag written in word four after descriptor and data finish.
// - Frame-end pointer follows the complete indication in a single-section frame, precedes it otherwise.
// - Single-section frame writes its own descriptor address as pointer.
// - Data moves from the receive FIFO while it holds bytes.
// - Full buffer: write count, mark complete, branch to next descriptor.
// - Frame end: pointer to first descriptor, interrupt, last count and status.
// - Status byte tells normal end, receiver reset end or hold end.
// - Frame status byte passes unmodified after the last data byte.
// - Character modes may store a status byte after every data byte.
// - Partial words are flushed when the FIFO empties, leaving gaps.
// - Count never exceeds size; overflowing status byte moves to next buffer.
// - Mode bit selects hold-bit or last-address list control.

module rxd_dma (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_end,
  input wire [7:0] rx_char_status,
  output reg rx_ready,
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [3:0] mem_len,
  output reg [31:0] mem_wdata,
  input wire mem_ready,
  input wire [31:0] mem_rdata,
  output reg frame_end_irq,
  output reg host_requested_irq
);

  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_FETCH = 6'h02;
  localparam [5:0] S_RECV = 6'h04;
  localparam [5:0] S_WDATA = 6'h08;
  localparam [5:0] S_WDESC = 6'h10;
  localparam [5:0] S_WPTR = 6'h20;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [31:0] base_addr;
  reg [31:0] last_addr;
  reg list_control_select;
  reg char_status_store_enable;
  reg char_mode;
  reg start_pulse;
  reg rst_pulse;
  reg [5:0] state;
  reg [31:0] cur_desc;
  reg [31:0] next_desc;
  reg [31:0] dbuf;
  reg [31:0] w0;
  reg [1:0] fcnt;
  reg hold;
  reg stopped;
  reg [13:0] buf_off;
  reg [31:0] wbuf;
  reg [2:0] lane;
  reg wlast;
  reg [12:0] stored_byte_count;
  reg frame_active;
  reg [31:0] frame_first;
  reg frame_end_flag;
  reg [7:0] end_code;
  reg ptr_after;
  reg desc_after;
  reg stat_pend;
  reg [7:0] stat_byte;
  reg end_pend;
  reg rst_req;
  wire setup = psel & ~penable;
  // size field position fixed by constant
  wire [12:0] dsize = {w0[`RXD_SIZE_MSB:2], 2'b00};
  wire take = rx_valid & rx_ready;
  wire [31:0] desc_word3 = {1'b1, frame_end_flag, 6'h00, end_code, 3'h0, stored_byte_count};

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states: data is latched in setup, pready rises in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      base_addr <= 32'h0000_0000;
      last_addr <= 32'h0000_0000;
      {char_mode, char_status_store_enable, list_control_select} <= 3'h0;
      start_pulse <= 1'b0;
      rst_pulse <= 1'b0;
    end else begin
      pready <= setup;
      start_pulse <= 1'b0;
      rst_pulse <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (setup) begin
        case (paddr)
          `RXD_REG_CTRL: prdata <= {28'h0, char_mode, char_status_store_enable,
                                    list_control_select, 1'b0};
          `RXD_REG_BASE: prdata <= base_addr;
          `RXD_REG_LAST: prdata <= last_addr;
          `RXD_REG_STAT: prdata <= {16'h0, 6'h0, stopped, frame_active, 2'b00, state};
          `RXD_REG_CUR: prdata <= cur_desc;
          default: pslverr <= 1'b1;
        endcase
        if (pwrite) begin
          case (paddr)
            `RXD_REG_CTRL: begin
              list_control_select <= pwdata[`RXD_CTRL_LSEL];
              char_status_store_enable <= pwdata[`RXD_CTRL_CSSE];
              char_mode <= pwdata[`RXD_CTRL_CHAR];
              start_pulse <= pwdata[`RXD_CTRL_START];
              rst_pulse <= pwdata[`RXD_CTRL_RRST];
            end
            `RXD_REG_BASE: base_addr <= pwdata;
            `RXD_REG_LAST: last_addr <= pwdata;
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Memory request helpers
  // ----------------------------------------
  task go_write;
    input [31:0] a;
    input [31:0] d;
    input [5:0] s;
    begin
      mem_req <= 1'b1;
      mem_we <= 1'b1;
      mem_addr <= a;
      mem_wdata <= d;
      mem_len <= 4'h1;
      state <= s;
    end
  endtask

  // Close a frame: order of writes depends on where the frame began
  task close_frame;
    input [7:0] code;
    begin
      frame_end_flag <= 1'b1;
      end_code <= code;
      if (!frame_active || frame_first == cur_desc) begin
        ptr_after <= 1'b1;
        desc_after <= 1'b0;
        go_write(cur_desc + `RXD_OFF_W3,
                 {1'b1, 1'b1, 6'h00, code, 3'h0, stored_byte_count}, S_WDESC);
      end else begin
        // pointer into first descriptor, count and status last
        ptr_after <= 1'b0;
        desc_after <= 1'b1;
        go_write(frame_first + `RXD_OFF_W4, cur_desc, S_WPTR);
      end
    end
  endtask

  // full buffer: count and completion, no frame end
  task close_buf;
    input [7:0] code;
    begin
      frame_end_flag <= 1'b0;
      end_code <= code;
      ptr_after <= 1'b0;
      desc_after <= 1'b0;
      // word offsets inside the five-word descriptor
      go_write(cur_desc + `RXD_OFF_W3,
               {1'b1, 1'b0, 6'h00, code, 3'h0, stored_byte_count}, S_WDESC);
    end
  endtask

  // Descriptor done: pulse interrupts, then branch or stop
  task finish_desc;
    begin
      mem_req <= 1'b0;
      frame_end_irq <= frame_end_flag;
      host_requested_irq <= w0[`RXD_W0_HI];
      stored_byte_count <= 13'h0000;
      if (frame_end_flag)
        frame_active <= 1'b0;
      if (hold) begin
        stopped <= 1'b1;
        state <= S_IDLE;
      end else begin
        cur_desc <= next_desc;
        mem_req <= 1'b1;
        mem_we <= 1'b0;
        mem_addr <= next_desc;
        mem_len <= `RXD_FETCH_LEN;
        fcnt <= 2'h0;
        state <= S_FETCH;
      end
    end
  endtask

  // Store one byte in the packing word and count it
  task put_byte;
    input [7:0] b;
    begin
      wbuf[{lane[1:0], 3'b000} +: 8] <= b;
      lane <= lane + 3'h1;
      stored_byte_count <= stored_byte_count + 13'h0001;
      if (!frame_active) begin
        frame_active <= 1'b1;
        frame_first <= cur_desc;
      end
    end
  endtask

  // ----------------------------------------
  // Channel sequencer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      rx_ready <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_len <= 4'h0;
      mem_wdata <= 32'h0000_0000;
      frame_end_irq <= 1'b0;
      host_requested_irq <= 1'b0;
      cur_desc <= 32'h0000_0000;
      next_desc <= 32'h0000_0000;
      dbuf <= 32'h0000_0000;
      w0 <= 32'h0000_0000;
      fcnt <= 2'h0;
      hold <= 1'b0;
      stopped <= 1'b0;
      buf_off <= 14'h0000;
      wbuf <= 32'h0000_0000;
      lane <= 3'h0;
      wlast <= 1'b0;
      stored_byte_count <= 13'h0000;
      frame_active <= 1'b0;
      frame_first <= 32'h0000_0000;
      frame_end_flag <= 1'b0;
      end_code <= `RXD_END_NORMAL;
      ptr_after <= 1'b0;
      desc_after <= 1'b0;
      stat_pend <= 1'b0;
      stat_byte <= 8'h00;
      end_pend <= 1'b0;
      rst_req <= 1'b0;
    end else begin
      frame_end_irq <= 1'b0;
      host_requested_irq <= 1'b0;
      if (start_pulse) begin
        cur_desc <= base_addr;
        stopped <= 1'b0;
        frame_active <= 1'b0;
        stored_byte_count <= 13'h0000;
        lane <= 3'h0;
        wbuf <= 32'h0000_0000;
        stat_pend <= 1'b0;
        rx_ready <= 1'b0;
        rst_req <= 1'b0;
        mem_req <= 1'b1;
        mem_we <= 1'b0;
        mem_addr <= base_addr;
        mem_len <= `RXD_FETCH_LEN;
        fcnt <= 2'h0;
        state <= S_FETCH;
      end else begin
        case (state)
          S_IDLE: begin
            rx_ready <= 1'b0;
          end
          S_FETCH: begin
            if (mem_ready) begin
              fcnt <= fcnt + 2'h1;
              case (fcnt)
                2'h0: w0 <= mem_rdata;
                2'h1: next_desc <= mem_rdata;
                default: begin
                  // data starts at the buffer pointer
                  dbuf <= mem_rdata;
                  buf_off <= 14'h0000;
                  mem_req <= 1'b0;
                  hold <= list_control_select ? (cur_desc == last_addr)
                                              : w0[`RXD_W0_HOLD];
                  if (w0[`RXD_SIZE_MSB:2] == 11'h000) begin
                    // Zero-size buffer completes without data
                    if (list_control_select ? (cur_desc == last_addr) : w0[`RXD_W0_HOLD])
                      close_buf(`RXD_END_HOLD);
                    else
                      close_buf(`RXD_END_NORMAL);
                  end else begin
                    state <= S_RECV;
                  end
                end
              endcase
            end
          end
          S_RECV: begin
            rx_ready <= 1'b0;
            if (rst_req && !stat_pend) begin
              rst_req <= 1'b0;
              if (lane != 3'h0) begin
                wlast <= 1'b1;
                end_code <= `RXD_END_RESET;
                go_write(dbuf + {18'h0, buf_off}, wbuf, S_WDATA);
              end else if (frame_active) begin
                close_frame(`RXD_END_RESET);
              end
            end else if (stat_pend) begin
              // character status follows its data byte
              put_byte(stat_byte);
              stat_pend <= 1'b0;
              if (lane == 3'h3 || end_pend) begin
                wlast <= end_pend;
                end_code <= `RXD_END_NORMAL;
                wbuf[{lane[1:0], 3'b000} +: 8] <= stat_byte;
                go_write(dbuf + {18'h0, buf_off},
                         wbuf | ({24'h0, stat_byte} << {lane[1:0], 3'b000}), S_WDATA);
              end
            end else if (take) begin
              // drain the FIFO byte by byte
              // frame status byte stored as received
              put_byte(rx_data);
              if (char_mode && char_status_store_enable) begin
                stat_pend <= 1'b1;
                stat_byte <= rx_char_status;
                end_pend <= rx_end;
              end
              if (lane == 3'h3 || (rx_end && !(char_mode && char_status_store_enable))) begin
                wlast <= rx_end;
                end_code <= `RXD_END_NORMAL;
                go_write(dbuf + {18'h0, buf_off},
                         wbuf | ({24'h0, rx_data} << {lane[1:0], 3'b000}), S_WDATA);
              end
            end else if (!rx_valid && lane != 3'h0) begin
              // partial word flushed, rest of word left as a gap
              wlast <= 1'b0;
              go_write(dbuf + {18'h0, buf_off}, wbuf, S_WDATA);
            end else begin
              // One byte every other cycle keeps ready a plain flop
              rx_ready <= ~rx_valid | ~rx_ready;
            end
          end
          S_WDATA: begin
            rx_ready <= 1'b0;
            if (mem_ready) begin
              mem_req <= 1'b0;
              buf_off <= buf_off + 14'h0004;
              lane <= 3'h0;
              wbuf <= 32'h0000_0000;
              if (wlast) begin
                // frame end after all data stored
                close_frame(end_code);
              end else if (buf_off + 14'h0008 > {1'b0, dsize}) begin
                // no room left: status byte goes to next buffer
                if (hold)
                  close_frame(`RXD_END_HOLD);
                else
                  close_buf(`RXD_END_NORMAL);
              end else begin
                state <= S_RECV;
              end
            end
          end
          S_WDESC: begin
            if (mem_ready) begin
              if (ptr_after) begin
                ptr_after <= 1'b0;
                go_write(cur_desc + `RXD_OFF_W4, cur_desc, S_WPTR);
              end else begin
                finish_desc;
              end
            end
          end
          S_WPTR: begin
            // pointer word into the frame's first descriptor
            if (mem_ready) begin
              if (desc_after) begin
                desc_after <= 1'b0;
                go_write(cur_desc + `RXD_OFF_W3, desc_word3, S_WDESC);
              end else begin
                finish_desc;
              end
            end
          end
          default: state <= S_IDLE;
        endcase
      end
      // Reset command waits until the packer can act on it; set beats clear
      if (rst_pulse)
        rst_req <= 1'b1;
    end
  end

endmodule

/* File: verif/rxd_dma_props.sv */
// Concurrent checks on the receive descriptor DMA ports
`timescale 1ns/1ps
module rxd_dma_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire rx_valid,
  input wire rx_ready,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [3:0] mem_len,
  input wire mem_ready,
  input wire frame_end_irq,
  input wire host_requested_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero-wait answer, exactly one access cycle
  a_apb_zero_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  // Offsets above 0x10 are refused, mapped offset 0x04 is not
  a_slverr_unmapped: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
    else $error("unmapped access not refused");
  a_slverr_mapped: assert property (psel && !penable && paddr == 8'h04 |=> !pslverr)
    else $error("mapped access refused");
  // Memory request stands until each word is taken
  a_mem_req_hold: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_len)) else $error("memory request changed early");
  a_fetch_three: assert property (mem_req && !mem_we |-> mem_len == 4'h3)
    else $error("descriptor fetch length wrong");
  a_write_single: assert property (mem_req && mem_we |-> mem_len == 4'h1)
    else $error("write length wrong");
  a_addr_aligned: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("unaligned memory address");
  // at most one byte taken every two cycles
  a_rx_one_byte: assert property (rx_valid && rx_ready |=> !rx_ready)
    else $error("receive take not followed by a gap");
  a_fe_irq_pulse: assert property ($rose(frame_end_irq) |=> !frame_end_irq)
    else $error("frame end interrupt too long");
  a_hi_irq_pulse: assert property (host_requested_irq |=> !host_requested_irq)
    else $error("host interrupt too long");
endmodule
bind rxd_dma rxd_dma_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_len(mem_len), .mem_ready(mem_ready), .frame_end_irq(frame_end_irq),
  .host_requested_irq(host_requested_irq));

/* File: verif/rxd_mem_model.sv */
// Shared host memory model on the far side of the DMA bus
`timescale 1ns/1ps
module rxd_mem_model (
  input wire pclk,
  input wire presetn,
  input wire slow,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [3:0] mem_len,
  input wire [31:0] mem_wdata,
  output reg mem_ready,
  output wire [31:0] mem_rdata
);
  reg [31:0] mem [0:1023];
  reg [3:0] k;
  reg gap;
  // five-word descriptors held as aligned words
  wire [9:0] idx = mem_addr[11:2] + {6'h0, k};
  // Outside a beat the data lines show garbage, never the last word
  assign mem_rdata = mem_ready ? mem[idx] : ~mem[idx];
  // One word per ready beat; slow mode leaves two idle cycles before each word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ready <= 1'b0;
      k <= 4'h0;
      gap <= 1'b0;
    end else if (mem_req && mem_ready) begin
      if (mem_we)
        mem[idx] <= mem_wdata;
      if (k + 4'h1 == mem_len) begin
        k <= 4'h0;
        mem_ready <= 1'b0;
      end else begin
        k <= k + 4'h1;
        mem_ready <= !slow;
      end
    end else if (mem_req) begin
      if (slow && !gap) begin
        gap <= 1'b1;
      end else begin
        mem_ready <= 1'b1;
        gap <= 1'b0;
      end
    end else begin
      mem_ready <= 1'b0;
    end
  end
endmodule

/* File: verif/tb_rx_descriptor_list_dma.sv */
// Directed testbench for the receive descriptor DMA channel
`timescale 1ns/1ps
`include "rxd_consts.vh"
module tb_rx_descriptor_list_dma;
  reg pclk, presetn, psel, penable, pwrite, rx_valid, rx_end, slow;
  reg [7:0] paddr, rx_data, rx_char_status;
  reg [31:0] pwdata, rd;
  reg err;
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
  wire [3:0] mem_len;
  wire pready, pslverr, rx_ready, mem_req, mem_we, mem_ready, frame_end_irq, host_requested_irq;
  integer fails, samples_checked, fe_cnt, hi_cnt, n, t;
  rxd_dma dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .rx_char_status(rx_char_status), .rx_ready(rx_ready), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_len(mem_len), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .frame_end_irq(frame_end_irq),
    .host_requested_irq(host_requested_irq));
  rxd_mem_model u_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_len(mem_len), .mem_wdata(mem_wdata),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Interrupt pulse counters
  always @(posedge pclk) begin
    if (frame_end_irq === 1'b1) fe_cnt = fe_cnt + 1;
    if (host_requested_irq === 1'b1) hi_cnt = hi_cnt + 1;
  end
  task chk(input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  endtask
  // APB transfer: setup, access until pready, then release
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin @(posedge pclk); t = t + 1; end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) fails = fails + 1;
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  // Receive byte held valid until taken; keeps valid up for back-to-back bytes
  task rx_byte(input [7:0] b, input e);
    begin
      rx_valid <= 1'b1; rx_data <= b; rx_end <= e; rx_char_status <= ~b;
      t = 0;
      do begin @(posedge pclk); t = t + 1; end while (rx_ready !== 1'b1 && t < 3000);
      if (rx_ready !== 1'b1) fails = fails + 1;
    end
  endtask
  task wait_fe(input integer c);
    begin
      t = 0;
      while (fe_cnt < c && t < 5000) begin @(posedge pclk); t = t + 1; end
      if (fe_cnt < c) fails = fails + 1;
    end
  endtask
  task wrap_up;
    begin
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #200000;
    fails = fails + 1;
    wrap_up;
  end
  initial begin
    fails = 0; samples_checked = 0; fe_cnt = 0; hi_cnt = 0; slow = 1'b0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; rx_valid = 1'b0; rx_end = 1'b0; rx_data = 8'h00; rx_char_status = 8'h00;
    // descriptor chain 0x100 -> 0x200 -> 0x300 (hold), sizes multiples of four
    for (n = 0; n < 1024; n = n + 1) u_mem.mem[n] = 32'hffff_ffff;
    u_mem.mem[64] = 32'h0000_0010; u_mem.mem[65] = 32'h0000_0200; u_mem.mem[66] = 32'h0000_0400;
    u_mem.mem[128] = 32'h4000_0004; u_mem.mem[129] = 32'h0000_0300;
    u_mem.mem[130] = 32'h0000_0500;
    u_mem.mem[192] = 32'h8000_0010; u_mem.mem[193] = 32'h0000_0100;
    u_mem.mem[194] = 32'h0000_0600;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Registers and refusal
    apb(1'b0, `RXD_REG_CTRL, 32'h0); chk(32'h0, rd);
    apb(1'b1, `RXD_REG_BASE, 32'h0000_0100);
    apb(1'b0, `RXD_REG_BASE, 32'h0); chk(32'h0000_0100, rd);
    apb(1'b0, 8'h40, 32'h0); chk(32'h1, {31'h0, err}); chk(32'h0, rd);
    $display("test registers done");
    // Single-section frame, one byte, fast memory
    apb(1'b1, `RXD_REG_CTRL, 32'h0000_0001);
    rx_byte(8'ha5, 1'b1);
    rx_valid <= 1'b0; rx_data <= 8'h5a;
    wait_fe(1);
    chk(32'h0000_00a5, u_mem.mem[256] & 32'h0000_00ff);
    chk(32'hc000_0001, u_mem.mem[67]);
    chk(32'h0000_0100, u_mem.mem[68]);
    $display("test single frame done");
    // Two-section frame with slow memory; second descriptor holds
    slow <= 1'b1;
    for (n = 0; n < 6; n = n + 1) rx_byte(8'h10 + n[7:0], n == 5);
    rx_valid <= 1'b0; rx_data <= 8'h00;
    wait_fe(2);
    repeat (20) @(posedge pclk);
    chk(32'h1312_1110, u_mem.mem[320]);
    chk(32'h0000_1514, u_mem.mem[384] & 32'h0000_ffff);
    chk(32'h8000_0004, u_mem.mem[131]);
    chk(32'h0000_0300, u_mem.mem[132]);
    chk(32'hc000_0002, u_mem.mem[195]);
    chk(32'hffff_ffff, u_mem.mem[196]);
    chk(32'h1, hi_cnt);
    chk(32'h2, fe_cnt);
    apb(1'b0, `RXD_REG_STAT, 32'h0); chk(32'h0000_0200, rd & 32'h0000_0200);
    apb(1'b0, `RXD_REG_CUR, 32'h0); chk(32'h0000_0300, rd);
    $display("test two sections done");
    // Last-address mode, character status stored, second frame cut by receiver reset
    u_mem.mem[64] = 32'h8000_0008; u_mem.mem[128] = 32'h0000_0008;
    apb(1'b1, `RXD_REG_LAST, 32'h0000_0200);
    apb(1'b1, `RXD_REG_CTRL, 32'h0000_000f);
    for (n = 0; n < 4; n = n + 1) rx_byte(8'h21 + n[7:0], n == 3);
    rx_valid <= 1'b0;
    wait_fe(3);
    chk(32'hdd22_de21, u_mem.mem[256]);
    chk(32'hdb24_dc23, u_mem.mem[257]);
    chk(32'hc000_0008, u_mem.mem[67]);
    chk(32'h0000_0100, u_mem.mem[68]);
    rx_byte(8'h77, 1'b0);
    rx_valid <= 1'b0;
    apb(1'b1, `RXD_REG_CTRL, 32'h0000_001e);
    wait_fe(4);
    chk(32'h0000_8877, u_mem.mem[320]);
    chk(32'hc001_0002, u_mem.mem[131]);
    chk(32'h0000_0200, u_mem.mem[132]);
    apb(1'b0, `RXD_REG_CUR, 32'h0); chk(32'h0000_0200, rd);
    $display("test last address done");
    wrap_up;
  end
endmodule
